// ### hdl/arc_ctrl.sv
`timescale 1ns/100ps
`include "arc_defs.svh"
// Summary of operation
// - unipolar codes are straight binary
// - main code scales by gain over 1.024 reference
// - aux gives 16-bit codes, gain 1 or 2
// - bipolar codes are offset binary
// - main bipolar code centred at half scale
// - aux bipolar code centred at two to fifteen
// - burnout bit drives both currents together
// - two excitation sources, separate or combined
// - converter clock from pll locked to crystal
// - keep-alive bit holds oscillator in power-down
// - low or open reference sets missing flag
// - missing reference forces results to all ones only in the calibration idle state
// - missing reference in calibration blocks coefficients, errors
// - reset returns all registers to defaults
// - reset drives ready high, ignores accesses
// - polarity bit changes coding only
module arc_ctrl #(
    parameter int MAIN_W = 24,
    parameter int AUX_W = 16,
    parameter int OSC_START_CYC = `ARC_OSC_START_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [MAIN_W-1:0] main_filt_word,
    input wire logic main_filt_valid,
    input wire logic [AUX_W-1:0] aux_filt_word,
    input wire logic aux_filt_valid,
    input wire logic ref_low_pin,
    input wire logic ref_open_pin,
    input wire logic pll_locked_pin,
    input wire logic cal_start,
    input wire logic cal_end,
    input wire logic [MAIN_W-1:0] cal_coef,
    input wire logic cal_is_gain,
    input wire logic power_down,
    output logic data_ready_b,
    output logic burnout_current_enable,
    output logic excitation_out_a,
    output logic excitation_out_b,
    output logic excitation_double,
    output logic oscillator_keep_alive,
    output logic aux_range_select,
    output logic osc_run,
    output logic conv_enable,
    output logic filter_clear
);
    // refused at elaboration: coder and register map assume these widths
    if (MAIN_W != 24 || AUX_W != 16) begin : g_bad_width
        $error("arc_ctrl supports 24-bit main and 16-bit aux only");
    end
    if (OSC_START_CYC < 1) begin : g_bad_wait
        $error("arc_ctrl oscillator wait must be at least one cycle");
    end

    localparam int OSC_W = $clog2(OSC_START_CYC + 1);
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_START_CYC);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    arc_pkg::arc_mode_t mode_r;
    arc_pkg::arc_ioctl_t ioc_r;
    arc_pkg::arc_cal_state_t cal_st_r;
    arc_pkg::arc_cal_state_t cal_st_nxt;
    logic [MAIN_W-1:0] main_data_r;
    logic [AUX_W-1:0] aux_data_r;
    logic [MAIN_W-1:0] main_ofs_r;
    logic [MAIN_W-1:0] main_gain_r;
    logic main_rdy_r;
    logic aux_rdy_r;
    logic main_err_r;
    logic cal_bad_r;
    logic [31:0] reg_rdata_r;
    logic [2:0] ref_low_s_r;
    logic [2:0] ref_open_s_r;
    logic [2:0] lock_s_r;
    logic missing_r;
    logic [OSC_W-1:0] osc_cnt_r;
    logic osc_ok_r;
    logic [7:0] out_r;
    logic conv_en_r;
    logic filt_clr_r;

    // two-stage synchronisers; stage one feeds only stage two
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_low_s_r <= 3'h0;
            ref_open_s_r <= 3'h0;
            lock_s_r <= 3'h0;
        end else begin
            ref_low_s_r <= {ref_low_s_r[1:0], ref_low_pin};
            ref_open_s_r <= {ref_open_s_r[1:0], ref_open_pin};
            lock_s_r <= {lock_s_r[1:0], pll_locked_pin};
        end
    end

    wire ref_low_q = ref_low_s_r[1];
    wire ref_open_q = ref_open_s_r[1];
    wire pll_lock_q = lock_s_r[1];
    wire missing_nxt = ref_low_q | ref_open_q;

    // bus decode; the reset itself gates every access
    wire wr_mode = reg_wr & hit(reg_addr, `ARC_ADDR_MODE);
    wire wr_ioc = reg_wr & hit(reg_addr, `ARC_ADDR_IOCTL);
    wire rd_status = reg_rd & hit(reg_addr, `ARC_ADDR_STATUS);
    wire rd_main = reg_rd & hit(reg_addr, `ARC_ADDR_MAIN_DATA);
    wire rd_aux = reg_rd & hit(reg_addr, `ARC_ADDR_AUX_DATA);

    wire [4:0] status_w = {cal_st_r != arc_pkg::ARC_CAL_IDLE, main_err_r, missing_r,
        aux_rdy_r, main_rdy_r};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_addr)
            `ARC_ADDR_MODE: rd_mux = {27'h0, mode_r};
            `ARC_ADDR_IOCTL: rd_mux = {27'h0, ioc_r};
            `ARC_ADDR_STATUS: rd_mux = {27'h0, status_w};
            `ARC_ADDR_MAIN_DATA: rd_mux = {8'h00, main_data_r};
            `ARC_ADDR_AUX_DATA: rd_mux = {16'h0000, aux_data_r};
            `ARC_ADDR_MAIN_OFS: rd_mux = {8'h00, main_ofs_r};
            `ARC_ADDR_MAIN_GAIN: rd_mux = {8'h00, main_gain_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // result coding with reference clamp
    wire [MAIN_W-1:0] main_code;
    wire [AUX_W-1:0] aux_code;
    wire clamp_on = missing_r & (cal_st_r == arc_pkg::ARC_CAL_IDLE);

    arc_coder #(.WIDTH(MAIN_W)) u_main_coder (
        .filt_word(main_filt_word),
        .bipolar(mode_r.main_bipolar),
        .word24(mode_r.word24),
        .clamp(clamp_on),
        .code(main_code)
    );

    arc_coder #(.WIDTH(AUX_W)) u_aux_coder (
        .filt_word(aux_filt_word),
        .bipolar(mode_r.aux_bipolar),
        .word24(1'b0),
        .clamp(clamp_on),
        .code(aux_code)
    );

    // calibration sequencing
    always_comb begin
        cal_st_nxt = cal_st_r;
        case (cal_st_r)
            arc_pkg::ARC_CAL_IDLE: if (cal_start) begin
                cal_st_nxt = arc_pkg::ARC_CAL_RUN;
            end
            arc_pkg::ARC_CAL_RUN: if (cal_end) begin
                cal_st_nxt = arc_pkg::ARC_CAL_DONE;
            end
            arc_pkg::ARC_CAL_DONE: cal_st_nxt = arc_pkg::ARC_CAL_IDLE;
            default: cal_st_nxt = arc_pkg::ARC_CAL_IDLE;
        endcase
    end

    wire in_cal = cal_st_r == arc_pkg::ARC_CAL_RUN;
    wire cal_fail = in_cal & (missing_r | cal_bad_r);
    wire coef_load = in_cal & cal_end & ~cal_fail;
    // a calibration start while error sets: set wins
    wire err_set = in_cal & cal_end & cal_fail;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_st_r <= arc_pkg::ARC_CAL_IDLE;
            cal_bad_r <= 1'b0;
            main_err_r <= 1'b0;
            main_ofs_r <= `ARC_OFS_RST;
            main_gain_r <= `ARC_GAIN_RST;
        end else begin
            cal_st_r <= cal_st_nxt;
            cal_bad_r <= in_cal ? (cal_bad_r | missing_r) : 1'b0;
            if (err_set) begin
                main_err_r <= 1'b1;
            end else if (cal_start && cal_st_r == arc_pkg::ARC_CAL_IDLE) begin
                main_err_r <= 1'b0;
            end
            if (coef_load && !cal_is_gain) begin
                main_ofs_r <= cal_coef;
            end
            if (coef_load && cal_is_gain) begin
                main_gain_r <= cal_coef;
            end
        end
    end

    // control registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= `ARC_MODE_RST;
            ioc_r <= `ARC_IOC_RST;
            missing_r <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_r <= reg_wdata[4:0];
            end
            if (wr_ioc) begin
                ioc_r <= reg_wdata[4:0];
            end
            missing_r <= missing_nxt;
        end
    end

    // results and ready flags; new result wins over read clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            main_data_r <= '0;
            aux_data_r <= '0;
            main_rdy_r <= 1'b0;
            aux_rdy_r <= 1'b0;
            reg_rdata_r <= 32'h0000_0000;
        end else begin
            if (main_filt_valid && !in_cal) begin
                main_data_r <= main_code;
            end
            if (aux_filt_valid && !in_cal) begin
                aux_data_r <= aux_code;
            end
            main_rdy_r <= (main_filt_valid & ~in_cal) | (main_rdy_r & ~rd_main);
            aux_rdy_r <= (aux_filt_valid & ~in_cal) | (aux_rdy_r & ~rd_aux);
            reg_rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // oscillator restart wait after leaving power-down
    wire osc_stop = power_down & ~mode_r.osc_keep;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_cnt_r <= '0;
            osc_ok_r <= 1'b0;
        end else if (osc_stop) begin
            osc_cnt_r <= '0;
            osc_ok_r <= 1'b0;
        end else if (!osc_ok_r) begin
            osc_cnt_r <= osc_cnt_r + OSC_W'(1);
            osc_ok_r <= osc_cnt_r == OSC_LAST - OSC_W'(1);
        end
    end

    // pins: burnout pair switched together, excitation routing
    wire exc_any = ioc_r.exc_a | ioc_r.exc_b;
    wire [7:0] out_nxt = {
        ioc_r.burnout,
        ioc_r.exc_route ? (exc_any & ~ioc_r.exc_pin) : ioc_r.exc_a,
        ioc_r.exc_route ? (exc_any & ioc_r.exc_pin) : ioc_r.exc_b,
        ioc_r.exc_route & ioc_r.exc_a & ioc_r.exc_b,
        mode_r.osc_keep,
        mode_r.aux_range,
        ~osc_stop,
        1'b0
    };

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_r <= 8'h00;
            conv_en_r <= 1'b0;
            filt_clr_r <= 1'b1;
            data_ready_b <= 1'b1;
        end else begin
            out_r <= out_nxt;
            // conversions run only on a locked pll and a settled crystal
            conv_en_r <= pll_lock_q & osc_ok_r & ~power_down;
            filt_clr_r <= 1'b0;
            data_ready_b <= ~(main_rdy_r | aux_rdy_r) | power_down;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign burnout_current_enable = out_r[7];
    assign excitation_out_a = out_r[6];
    assign excitation_out_b = out_r[5];
    assign excitation_double = out_r[4];
    assign oscillator_keep_alive = out_r[3];
    assign aux_range_select = out_r[2];
    assign osc_run = out_r[1];
    assign conv_enable = conv_en_r;
    assign filter_clear = filt_clr_r;
    wire unused_ok = &{1'b0, out_r[0], rd_status};
endmodule

// ### shared/arc_defs.svh
`ifndef ARC_DEFS_SVH
`define ARC_DEFS_SVH
// register byte addresses
`define ARC_ADDR_MODE 8'h00
`define ARC_ADDR_IOCTL 8'h04
`define ARC_ADDR_STATUS 8'h08
`define ARC_ADDR_MAIN_DATA 8'h0C
`define ARC_ADDR_AUX_DATA 8'h10
`define ARC_ADDR_MAIN_OFS 8'h14
`define ARC_ADDR_MAIN_GAIN 8'h18
// mode register fields
`define ARC_MODE_MAIN_BIPOLAR 0
`define ARC_MODE_AUX_BIPOLAR 1
`define ARC_MODE_WORD24 2
`define ARC_MODE_AUX_RANGE 3
`define ARC_MODE_OSC_KEEP 4
// io control register fields
`define ARC_IOC_BURNOUT 0
`define ARC_IOC_EXC_A 1
`define ARC_IOC_EXC_B 2
`define ARC_IOC_EXC_ROUTE 3
`define ARC_IOC_EXC_PIN 4
// status register fields
`define ARC_ST_MAIN_RDY 0
`define ARC_ST_AUX_RDY 1
`define ARC_ST_MISSING_REF 2
`define ARC_ST_MAIN_ERR 3
`define ARC_ST_CAL_BUSY 4
// reset values
`define ARC_MODE_RST 5'h00
`define ARC_IOC_RST 5'h00
`define ARC_OFS_RST 24'h800000
`define ARC_GAIN_RST 24'h400000
// oscillator restart wait and pll rates
`define ARC_OSC_START_MS 300
`define ARC_CLK_HZ 100000000
`define ARC_PLL_HZ 4194304
`define ARC_XTAL_HZ 32768
`define ARC_OSC_START_CYC ((`ARC_OSC_START_MS * (`ARC_CLK_HZ / 1000)))
`endif

// ### shared/arc_pkg.sv
package arc_pkg;
    // first member is the top bit: order follows the register map, bit 4 down to bit 0
    typedef struct packed {
        logic osc_keep;
        logic aux_range;
        logic word24;
        logic aux_bipolar;
        logic main_bipolar;
    } arc_mode_t;

    typedef struct packed {
        logic exc_pin;
        logic exc_route;
        logic exc_b;
        logic exc_a;
        logic burnout;
    } arc_ioctl_t;

    typedef struct packed {
        logic [23:0] code;
        logic valid;
    } arc_result_t;

    typedef enum logic [1:0] {
        ARC_CAL_IDLE = 2'b00,
        ARC_CAL_RUN = 2'b01,
        ARC_CAL_DONE = 2'b11
    } arc_cal_state_t;
endpackage

// ### hdl/arc_coder.sv
`timescale 1ns/100ps
`include "arc_defs.svh"
// codes a signed filter word into the output format of one converter
module arc_coder #(
    parameter int WIDTH = 24
) (
    input wire logic [WIDTH-1:0] filt_word,
    input wire logic bipolar,
    input wire logic word24,
    input wire logic clamp,
    output logic [WIDTH-1:0] code
);
    if (WIDTH != 24 && WIDTH != 16) begin : g_bad_width
        $error("arc_coder width must be 16 or 24");
    end

    // filter word is two's complement in bipolar, magnitude in unipolar
    wire [WIDTH-1:0] offset_bin = {~filt_word[WIDTH-1], filt_word[WIDTH-2:0]};
    wire [WIDTH-1:0] straight = filt_word;
    // coding only, no change to conditioning
    wire [WIDTH-1:0] coded = bipolar ? offset_bin : straight;
    // in 16-bit word mode the active code sits in the low half
    wire [WIDTH-1:0] narrow = (WIDTH == 24) ? WIDTH'({8'h00, coded[WIDTH-1 -: 16]}) : coded;
    wire [WIDTH-1:0] ones_w = (WIDTH == 24 && !word24) ? WIDTH'({8'h00, 16'hFFFF}) : '1;
    assign code = clamp ? ones_w : ((WIDTH == 24 && !word24) ? narrow : coded);
endmodule

// ### verif/arc_ctrl_monitor.sv
`timescale 1ns/100ps
module arc_ctrl_monitor (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic main_filt_valid,
    input wire logic ref_low_pin,
    input wire logic ref_open_pin,
    input wire logic power_down,
    input wire logic data_ready_b,
    input wire logic burnout_current_enable,
    input wire logic excitation_out_a,
    input wire logic excitation_out_b,
    input wire logic excitation_double,
    input wire logic oscillator_keep_alive,
    input wire logic aux_range_select,
    input wire logic filter_clear
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    property p_rst;
        $rose(rst_b) |-> (data_ready_b && filter_clear && !burnout_current_enable)
            ##1 !filter_clear;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_burn;
        logic [4:0] d;
        (reg_wr && reg_addr == 8'h04, d = reg_wdata[4:0]) |-> ##2 burnout_current_enable == d[0];
    endproperty
    a_burn: assert property (p_burn) else $error("burnout pin wrong");
    property p_exc_sep;
        logic [4:0] d;
        (reg_wr && reg_addr == 8'h04 && !reg_wdata[3], d = reg_wdata[4:0]) |-> ##2
            (!excitation_double && excitation_out_a == d[1] && excitation_out_b == d[2]);
    endproperty
    a_exc_sep: assert property (p_exc_sep) else $error("separate sources wrong");
    property p_exc_comb;
        logic [4:0] d;
        (reg_wr && reg_addr == 8'h04 && reg_wdata[3], d = reg_wdata[4:0]) |-> ##2
            (excitation_double == (d[1] && d[2])
            && excitation_out_b == ((d[1] || d[2]) && d[4])
            && excitation_out_a == ((d[1] || d[2]) && !d[4]));
    endproperty
    a_exc_comb: assert property (p_exc_comb) else $error("combined sources wrong");
    property p_mode;
        logic [4:0] d;
        (reg_wr && reg_addr == 8'h00, d = reg_wdata[4:0]) |-> ##2
            (oscillator_keep_alive == d[4] && aux_range_select == d[3]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode pins wrong");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    property p_unmapped;
        reg_rd && reg_addr > 8'h18 |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_miss;
        (ref_low_pin || ref_open_pin) [*4] ##1 (reg_rd && reg_addr == 8'h08) |=> reg_rdata[2];
    endproperty
    a_miss: assert property (p_miss) else $error("missing flag not set");
    property p_rdy;
        main_filt_valid && !power_down |-> ##[1:3] !data_ready_b;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready not asserted");
    property p_pd_rdy;
        power_down |=> data_ready_b;
    endproperty
    a_pd_rdy: assert property (p_pd_rdy) else $error("ready low in power-down");
    c_rst: cover property ($rose(rst_b));
    c_main: cover property (reg_rd && reg_addr == 8'h0C);
    c_comb: cover property (reg_wr && reg_addr == 8'h04 && reg_wdata[3]);
    c_pd_keep: cover property (power_down && oscillator_keep_alive);
endmodule
bind arc_ctrl arc_ctrl_monitor u_arc_ctrl_monitor (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_filt_valid(main_filt_valid),
    .ref_low_pin(ref_low_pin), .ref_open_pin(ref_open_pin), .power_down(power_down),
    .data_ready_b(data_ready_b), .burnout_current_enable(burnout_current_enable),
    .excitation_out_a(excitation_out_a), .excitation_out_b(excitation_out_b),
    .excitation_double(excitation_double), .oscillator_keep_alive(oscillator_keep_alive),
    .aux_range_select(aux_range_select), .filter_clear(filter_clear)
);

// ### verif/arc_host.sv
`timescale 1ns/100ps
// host controller on the register port
module arc_host (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'hFF;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // idle lines carry the inverse so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

// ### verif/tb_adc_result_coding_fault_control.sv
`timescale 1ns/100ps
module tb_adc_result_coding_fault_control;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, rd_pend = 1'b0;
    logic [23:0] main_filt_word = 24'h0, cal_coef = 24'h0, w, c1, c2;
    logic [15:0] aux_filt_word = 16'h0;
    logic main_filt_valid = 1'b0, aux_filt_valid = 1'b0, ref_low_pin = 1'b0;
    logic ref_open_pin = 1'b0, pll_locked_pin = 1'b1, cal_start = 1'b0, cal_end = 1'b0;
    logic cal_is_gain = 1'b0, power_down = 1'b0;
    logic data_ready_b, burnout_current_enable, excitation_out_a, excitation_out_b;
    logic excitation_double, oscillator_keep_alive, aux_range_select, osc_run;
    logic conv_enable, filter_clear;
    logic [23:0] wt[4] = '{24'h000000, 24'h800000, 24'hFFFFFF, 24'h000001};
    logic [4:0] ioc_v[5] = '{5'h01, 5'h06, 5'h1E, 5'h0E, 5'h1A};
    logic [3:0] ioc_e[5] = '{4'b1000, 4'b0110, 4'b0011, 4'b0101, 4'b0010};
    logic [31:0] exp_q[$];
    int error_cnt = 0, compares = 0;
    // short oscillator wait keeps the run brief
    arc_ctrl #(.OSC_START_CYC(20)) u_arc_ctrl (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .main_filt_word(main_filt_word), .main_filt_valid(main_filt_valid),
        .aux_filt_word(aux_filt_word), .aux_filt_valid(aux_filt_valid),
        .ref_low_pin(ref_low_pin), .ref_open_pin(ref_open_pin), .pll_locked_pin(pll_locked_pin),
        .cal_start(cal_start), .cal_end(cal_end), .cal_coef(cal_coef), .cal_is_gain(cal_is_gain),
        .power_down(power_down), .data_ready_b(data_ready_b),
        .burnout_current_enable(burnout_current_enable), .excitation_out_a(excitation_out_a),
        .excitation_out_b(excitation_out_b), .excitation_double(excitation_double),
        .oscillator_keep_alive(oscillator_keep_alive), .aux_range_select(aux_range_select),
        .osc_run(osc_run), .conv_enable(conv_enable), .filter_clear(filter_clear)
    );
    arc_host u_arc_host (
        .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd)
    );
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chp(string n, logic [3:0] e, logic [3:0] g);
        chk(n, {28'h0, e}, {28'h0, g});
    endtask
    task automatic pwr_chk(logic [3:0] e);
        #1 chp("pwr_pins", e, {data_ready_b, osc_run, conv_enable, oscillator_keep_alive});
    endtask
    task automatic pwr_set(logic pd, int n);
        @(posedge core_clk);
        power_down <= pd;
        repeat (n) @(posedge core_clk);
    endtask
    task automatic close_out();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // read data stand only in the cycle after the strobe
    always @(negedge core_clk) begin
        if (rd_pend) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        rd_pend = reg_rd;
    end
    task automatic rdx(logic [7:0] a, logic [31:0] e);
        exp_q.push_back(e);
        u_arc_host.rd(a);
    endtask
    task automatic sres(logic aux, logic [23:0] v);
        @(posedge core_clk);
        main_filt_word <= v;
        aux_filt_word <= v[15:0];
        main_filt_valid <= !aux;
        aux_filt_valid <= aux;
        @(posedge core_clk);
        main_filt_valid <= 1'b0;
        aux_filt_valid <= 1'b0;
    endtask
    function automatic logic [31:0] mcode(logic [23:0] v, logic bip, logic w24);
        logic [23:0] c;
        c = bip ? {~v[23], v[22:0]} : v;
        return w24 ? {8'h0, c} : {16'h0, c[23:8]};
    endfunction
    task automatic cal(logic g, logic [23:0] c, logic bad);
        @(posedge core_clk);
        cal_start <= 1'b1;
        cal_is_gain <= g;
        cal_coef <= c;
        @(posedge core_clk);
        cal_start <= 1'b0;
        ref_open_pin <= bad;
        repeat (5) @(posedge core_clk);
        rdx(8'h08, {27'h0, 2'b10, bad, 2'b00});
        ref_open_pin <= 1'b0;
        repeat (5) @(posedge core_clk);
        cal_end <= 1'b1;
        @(posedge core_clk);
        cal_end <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    initial begin
        #400000;
        error_cnt++;
        $display("FAIL watchdog exp finish got timeout");
        close_out();
    end
    initial begin
        void'($urandom(32'h14046380));
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (30) @(posedge core_clk);
        for (int m = 0; m < 32; m++) begin
            u_arc_host.wr(8'h00, 32'(m));
            repeat (2) @(posedge core_clk);
            #1 chp("mode_pins", {2'h0, m[4], m[3]}, {2'h0, oscillator_keep_alive, aux_range_select});
            for (int j = 0; j < 4; j++) begin
                w = (j == 3) ? 24'($urandom) : wt[j];
                sres(1'b0, w);
                rdx(8'h0C, mcode(w, m[0], m[2]));
                sres(1'b1, w);
                rdx(8'h10, {16'h0, w[15] ^ m[1], w[14:0]});
            end
        end
        $display("test coding done");
        for (int i = 0; i < 5; i++) begin
            u_arc_host.wr(8'h04, {27'h0, ioc_v[i]});
            repeat (2) @(posedge core_clk);
            #1 chp("ioc_pins", ioc_e[i], {burnout_current_enable, excitation_out_a,
                excitation_out_b, excitation_double});
            rdx(8'h04, {27'h0, ioc_v[i]});
        end
        $display("test sources done");
        u_arc_host.wr(8'h04, 32'h01);
        sres(1'b0, 24'h123456);
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b0;
        u_arc_host.wr(8'h00, 32'h1F);
        #1 chp("in_reset", 4'b1100, {data_ready_b, filter_clear, burnout_current_enable,
            oscillator_keep_alive});
        @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (30) @(posedge core_clk);
        rdx(8'h00, 32'h0);
        rdx(8'h04, 32'h0);
        rdx(8'h08, 32'h0);
        rdx(8'h14, 32'h00800000);
        rdx(8'h18, 32'h00400000);
        rdx(8'h40, 32'h0);
        $display("test reset done");
        ref_low_pin <= 1'b1;
        u_arc_host.wr(8'h00, 32'h07);
        sres(1'b0, 24'h000010);
        rdx(8'h0C, 32'h00FFFFFF);
        u_arc_host.wr(8'h00, 32'h03);
        sres(1'b0, 24'h000010);
        rdx(8'h0C, 32'h0000FFFF);
        sres(1'b1, 24'h000010);
        rdx(8'h10, 32'h0000FFFF);
        rdx(8'h08, 32'h4);
        ref_low_pin <= 1'b0;
        repeat (5) @(posedge core_clk);
        $display("test missing_ref done");
        c1 = 24'($urandom);
        c2 = 24'($urandom);
        cal(1'b0, c1, 1'b0);
        rdx(8'h14, {8'h0, c1});
        cal(1'b1, c2, 1'b0);
        rdx(8'h18, {8'h0, c2});
        rdx(8'h08, 32'h0);
        cal(1'b0, ~c1, 1'b1);
        rdx(8'h08, 32'h8);
        rdx(8'h14, {8'h0, c1});
        cal(1'b1, ~c2, 1'b1);
        rdx(8'h18, {8'h0, c2});
        rdx(8'h08, 32'h8);
        repeat (3) @(posedge core_clk);
        $display("test calibration done");
        sres(1'b0, 24'h000100);
        repeat (2) @(posedge core_clk);
        pwr_chk(4'b0110);
        pwr_set(1'b1, 3);
        pwr_chk(4'b1000);
        pwr_set(1'b0, 3);
        pwr_chk(4'b0100);
        repeat (20) @(posedge core_clk);
        pwr_chk(4'b0110);
        u_arc_host.wr(8'h00, 32'h10);
        pwr_set(1'b1, 3);
        pwr_chk(4'b1101);
        pwr_set(1'b0, 3);
        pwr_chk(4'b0111);
        pll_locked_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        pwr_chk(4'b0101);
        rdx(8'h0C, mcode(24'h000100, 1'b1, 1'b0));
        repeat (2) @(posedge core_clk);
        pwr_chk(4'b1101);
        pll_locked_pin <= 1'b1;
        $display("test power_down done");
        close_out();
    end
endmodule
